// *** rtl/cdrf_fallback.sv ***
// Purpose: decides when one dpll may use the other's feedback as reference
// Assumes: status inputs synchronous to pclk; apb slave on pclk
// Notes:   index p of outputs names the primary, secondary is the other dpll
//
// Local design decision: the APB register port.
`timescale 1ns/10ps

// Function
// R1: peer-feedback profile on secondary must exist
// R2: 3-bit fallback profile selector per dpll
// R3: selector resets zero, accepts profiles 0..5
// R4: primary apll calibrated and locked
// R5: primary dpll must be in freerun/holdover
// R6: offer primary feedback as secondary reference
// R7: secondary may briefly pass through holdover
// R8: roles follow profiles and selector only
// R9: software avoids reference sync with cascade
// R10: translation type decides extra conditions
// R11: hitless needs distribution sync on secondary
// R12: use primary feedback settings from target
// R13: only integer feedback divider while cascaded
// R14: software programs buildout divider always
// R15: software keeps external zero delay cleared
// R16: tags follow primary feedback tag mode
// R17: primary target tag mode 2, 3, 4
// R18: secondary cascade tag mode 1, 3, 4
// R19: no cascade: each dpll falls back alone
// R20: tag mode field codes five modes
// R21: withdraw offer once any condition fails
module cdrf_fallback #(
    parameter int NUM_PROF = cdrf_pkg::NUM_PROF
) (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [15:0]           paddr,
    input  wire logic [31:0]           pwdata,
    output logic [31:0]                prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire logic [1:0]            apll_calibrated,
    input  wire logic [1:0]            apll_locked,
    input  wire logic [1:0]            dpll_tracking,
    input  wire logic [1:0]            dist_synced,
    output logic [1:0]                 peer_fb_ref_valid,
    output logic [1:0]                 peer_fb_tag_avail,
    output logic [1:0][15:0]           cascade_fb_div_int
);
    typedef struct packed {
        cdrf_pkg::cdrf_state_type st;
        logic                     prim;
        logic [2:0]               k;
        logic                     found;
        logic                     t_hit;
        logic [2:0]               t_tag;
        logic [15:0]              t_int;
        logic [1:0][2:0]          sel;
        logic [1:0]               cfg_ok;
        logic [1:0]               hitless;
        logic [1:0][2:0]          ptag;
        logic [1:0][15:0]         fb_int;
        logic [1:0]               valid;
        logic [1:0]               tag_av;
        logic                     ack;
        logic                     wait_r;
        logic [31:0]              prdata;
    } cdrf_regs_type;

    cdrf_regs_type r_q;
    cdrf_regs_type r_d;

    cdrf_prof_if #(.AW(cdrf_pkg::PA_W), .DW(32)) prof ();

    logic        acc;
    logic        mem_hit;
    logic        sel0_hit;
    logic        sel1_hit;
    logic        stat_hit;
    logic        apb_mem;
    logic [1:0]  live;
    logic [31:0] rd_value;

    if (NUM_PROF < 1 || NUM_PROF > 8 || 2 * NUM_PROF > cdrf_pkg::PROF_WORDS) begin : g_chk
        $error("cdrf_fallback: profile count not supported");
    end

    ////////////////////////////////////////////////////////////////////////
    // helpers

    // profile table index of dpll d, profile y
    function automatic logic [3:0] prof_addr(input logic d, input logic [2:0] y);
        prof_addr = 4'({1'b0, y}) + (d ? 4'(NUM_PROF) : 4'h0);
    endfunction : prof_addr

    // modes 2,3,4 carry feedback tags
    function automatic logic has_fb_tag(input logic [2:0] m);
        has_fb_tag = (m == cdrf_pkg::TAG_FB) || (m == cdrf_pkg::TAG_COMB_EQ) ||
                     (m == cdrf_pkg::TAG_COMB_UNEQ); // [R20] [R17]
    endfunction : has_fb_tag

    ////////////////////////////////////////////////////////////////////////
    // apb decode
    assign acc      = psel && penable && !r_q.ack;
    assign mem_hit  = (paddr < cdrf_pkg::ADDR_PROF_END) && (paddr[1:0] == 2'b00);
    assign sel0_hit = (paddr == cdrf_pkg::ADDR_SEL0);
    assign sel1_hit = (paddr == cdrf_pkg::ADDR_SEL1);
    assign stat_hit = (paddr == cdrf_pkg::ADDR_STATUS);
    // bus owns the memory for the whole access, the scanner waits
    assign apb_mem  = psel && penable && mem_hit;

    // read mux; status word: valid, cfg_ok, tag_av from bit 0 up
    always_comb begin
        rd_value = 32'h0000_0000;
        if (mem_hit) begin
            rd_value = prof.rdata;
        end else if (sel0_hit) begin
            rd_value = 32'(r_q.sel[0]);
        end else if (sel1_hit) begin
            rd_value = 32'(r_q.sel[1]);
        end else if (stat_hit) begin
            rd_value = 32'({r_q.tag_av, r_q.cfg_ok, r_q.valid});
        end
    end

    // memory port mux
    always_comb begin
        prof.we    = 1'b0;
        prof.wdata = pwdata;
        prof.addr  = paddr[5:2];
        if (apb_mem) begin
            prof.we = r_q.ack && pwrite; // write lands on the pready edge
        end else if (r_q.st == cdrf_pkg::ST_ISSUE_P) begin
            prof.addr = prof_addr(r_q.prim, r_q.sel[r_q.prim]); // [R12]
        end else begin
            prof.addr = prof_addr(!r_q.prim, r_q.k);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // live entry conditions per primary p, secondary !p
    always_comb begin
        for (int p = 0; p < cdrf_pkg::NUM_DPLL; p++) begin
            live[p] = apll_calibrated[p] && apll_locked[p] // [R4] [R10]
                   && !dpll_tracking[p]                    // [R5]
                   && (!r_q.hitless[p] || dist_synced[1 - p]); // [R11]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        r_d = r_q;

        // apb: first access cycle loads data, second gives pready; memory reads load on the second and give pready on the third
        r_d.ack = 1'b0;
        if (acc) begin
            if (mem_hit && !pwrite && !r_q.wait_r) begin
                r_d.wait_r = 1'b1; // registered memory read needs a cycle
            end else begin
                r_d.wait_r = 1'b0;
                r_d.ack    = 1'b1;
                r_d.prdata = pwrite ? r_q.prdata : rd_value;
            end
        end

        // selector write; values whose low three bits exceed 5 are dropped
        if (psel && penable && r_q.ack && pwrite && pwdata[2:0] <= cdrf_pkg::SEL_MAX) begin
            if (sel0_hit) begin
                r_d.sel[0] = pwdata[cdrf_pkg::SEL_W-1:0]; // [R2] [R3]
            end
            if (sel1_hit) begin
                r_d.sel[1] = pwdata[cdrf_pkg::SEL_W-1:0]; // [R2] [R3]
            end
        end

        // scanner: primary target profile, then all secondary profiles
        case (r_q.st)
            cdrf_pkg::ST_ISSUE_P: begin
                if (!apb_mem) begin
                    r_d.st = cdrf_pkg::ST_TAKE_P;
                end
            end
            cdrf_pkg::ST_TAKE_P: begin
                // only type, tag and integer divider are kept
                r_d.t_hit = prof.rdata[cdrf_pkg::PF_HITLESS]; // [R10]
                r_d.t_tag = prof.rdata[cdrf_pkg::PF_TAG_LO +: cdrf_pkg::PF_TAG_W];
                r_d.t_int = prof.rdata[cdrf_pkg::PF_INT_LO +: cdrf_pkg::PF_INT_W]; // [R13]
                r_d.k     = 3'h0;
                r_d.found = 1'b0;
                r_d.st    = cdrf_pkg::ST_ISSUE_S;
            end
            cdrf_pkg::ST_ISSUE_S: begin
                if (!apb_mem) begin
                    r_d.st = cdrf_pkg::ST_TAKE_S;
                end
            end
            cdrf_pkg::ST_TAKE_S: begin
                if (prof.rdata[cdrf_pkg::PF_PEER]) begin
                    r_d.found = 1'b1; // [R1]
                end
                if (r_q.k == 3'(NUM_PROF - 1)) begin
                    r_d.st = cdrf_pkg::ST_EVAL;
                end else begin
                    r_d.k  = r_q.k + 3'h1;
                    r_d.st = cdrf_pkg::ST_ISSUE_S;
                end
            end
            cdrf_pkg::ST_EVAL: begin
                // commit at once; cascade_fb_div_int takes the new scan one cycle before the valid and tag outputs
                r_d.cfg_ok[r_q.prim]  = r_q.found; // [R1] [R8]
                r_d.hitless[r_q.prim] = r_q.t_hit;
                r_d.ptag[r_q.prim]    = r_q.t_tag;
                r_d.fb_int[r_q.prim]  = r_q.t_int; // [R12] [R13]
                r_d.prim              = !r_q.prim; // symmetric roles [R8]
                r_d.st                = cdrf_pkg::ST_ISSUE_P;
            end
            default: begin
                r_d.st = cdrf_pkg::ST_ISSUE_P;
            end
        endcase

        // offer follows conditions every cycle; drop is one cycle late
        // a secondary already in holdover picks it up on its next search
        for (int p = 0; p < cdrf_pkg::NUM_DPLL; p++) begin
            r_d.valid[p]  = r_q.cfg_ok[p] && live[p]; // [R6] [R21] [R7] [R19]
            r_d.tag_av[p] = r_q.cfg_ok[p] && live[p] && has_fb_tag(r_q.ptag[p]); // [R16]
        end
    end

    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r_q     <= '0;
            r_q.st  <= cdrf_pkg::ST_ISSUE_P;
            r_q.sel <= {cdrf_pkg::SEL_RST, cdrf_pkg::SEL_RST}; // [R3]
        end else begin
            r_q <= r_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs
    assign pready             = r_q.ack;
    assign pslverr            = r_q.ack && !(mem_hit || sel0_hit || sel1_hit || stat_hit);
    assign prdata             = r_q.prdata;
    assign peer_fb_ref_valid  = r_q.valid;
    assign peer_fb_tag_avail  = r_q.tag_av;
    assign cascade_fb_div_int = r_q.fb_int;

    cdrf_prof_mem #(
        .DEPTH (cdrf_pkg::PROF_WORDS),
        .DW    (32)
    ) u_mem (
        .pclk    (pclk),
        .presetn (presetn),
        .port    (prof.mem)
    );

    ////////////////////////////////////////////////////////////////////////
    // checks
    chk_sel_range: assert property (@(posedge pclk) disable iff (!presetn) // [R3]
        r_q.sel[0] <= cdrf_pkg::SEL_MAX && r_q.sel[1] <= cdrf_pkg::SEL_MAX)
        else $error("selector out of range");

    chk_sel_write: assert property (@(posedge pclk) disable iff (!presetn) // [R2]
        (psel && penable && pready && pwrite && sel0_hit && pwdata[2:0] <= cdrf_pkg::SEL_MAX)
        |=> r_q.sel[0] == $past(pwdata[2:0]))
        else $error("selector write lost");

    chk_eval_int: assert property (@(posedge pclk) disable iff (!presetn) // [R13]
        (r_q.st == cdrf_pkg::ST_EVAL) |=> r_q.fb_int[$past(r_q.prim)] == $past(r_q.t_int))
        else $error("integer divider not committed");

    chk_apb_ready: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && penable && !pready) |-> ##[1:2] pready)
        else $error("apb answer late");

    for (genvar g = 0; g < 2; g++) begin : g_chk_dpll
        chk_valid_apll: assert property (@(posedge pclk) disable iff (!presetn) // [R4]
            peer_fb_ref_valid[g] |-> $past(apll_calibrated[g] && apll_locked[g]))
            else $error("offer without apll lock");

        chk_valid_idle: assert property (@(posedge pclk) disable iff (!presetn) // [R5]
            peer_fb_ref_valid[g] |-> !$past(dpll_tracking[g]))
            else $error("offer while primary tracks");

        chk_valid_cfg: assert property (@(posedge pclk) disable iff (!presetn) // [R1]
            peer_fb_ref_valid[g] |-> $past(r_q.cfg_ok[g]))
            else $error("offer without peer profile");

        chk_hitless_sync: assert property (@(posedge pclk) disable iff (!presetn) // [R11]
            (peer_fb_ref_valid[g] && $past(r_q.hitless[g])) |-> $past(dist_synced[1 - g]))
            else $error("hitless offer without sync");

        chk_offer_drop: assert property (@(posedge pclk) disable iff (!presetn) // [R21]
            (peer_fb_ref_valid[g] && (!apll_locked[g] || dpll_tracking[g]))
            |=> !peer_fb_ref_valid[g])
            else $error("offer not withdrawn");

        chk_tag_fb: assert property (@(posedge pclk) disable iff (!presetn) // [R16]
            peer_fb_tag_avail[g] |-> peer_fb_ref_valid[g] && has_fb_tag($past(r_q.ptag[g])))
            else $error("tags without feedback tagging");

        cov_offer: cover property (@(posedge pclk) disable iff (!presetn)
            $rose(peer_fb_ref_valid[g]));
    end

    cov_drop: cover property (@(posedge pclk) disable iff (!presetn)
        $fell(peer_fb_ref_valid[0]));

    cov_tags: cover property (@(posedge pclk) disable iff (!presetn)
        peer_fb_tag_avail[1]);
endmodule : cdrf_fallback

// *** inc/cdrf_pkg.sv ***
// Purpose: constants and types for the cascaded dpll reference fallback
// Assumes: apb data of 32 bits, 16-bit byte addresses
// Notes:   selector registers are word indices; byte address is index times four
package cdrf_pkg;
    localparam int          NUM_DPLL       = 2;
    localparam int          NUM_PROF       = 6;
    localparam int          PA_W           = 4;   // profile memory index width
    localparam int          PROF_WORDS     = 12;
    // register indices as printed, byte addresses derived
    localparam logic [15:0] IDX_SEL0       = 16'h102a;
    localparam logic [15:0] IDX_SEL1       = 16'h142a;
    localparam logic [15:0] ADDR_SEL0      = 16'(IDX_SEL0 << 2);
    localparam logic [15:0] ADDR_SEL1      = 16'(IDX_SEL1 << 2);
    // profile table and status word
    localparam logic [15:0] ADDR_PROF_END  = 16'h0030;
    localparam logic [15:0] ADDR_STATUS    = 16'h0040;
    // fallback profile selector field
    localparam int          SEL_W          = 3;
    localparam logic [2:0]  SEL_RST        = 3'h0;
    localparam logic [2:0]  SEL_MAX        = 3'h5;
    // profile word layout
    localparam int          PF_PEER        = 0;   // reference is the peer feedback path
    localparam int          PF_HITLESS     = 1;   // 1 hitless internal, 0 phase buildout
    localparam int          PF_TAG_LO      = 2;
    localparam int          PF_TAG_W       = 3;
    localparam int          PF_EXT_ZD      = 5;
    localparam int          PF_INT_LO      = 8;
    localparam int          PF_INT_W       = 16;
    localparam int          PF_FRAC_LO     = 24;
    // tag mode codes
    localparam logic [2:0]  TAG_NONE       = 3'h0;
    localparam logic [2:0]  TAG_REF        = 3'h1;
    localparam logic [2:0]  TAG_FB         = 3'h2;
    localparam logic [2:0]  TAG_COMB_EQ    = 3'h3;
    localparam logic [2:0]  TAG_COMB_UNEQ  = 3'h4;
    // configuration scanner states
    typedef enum logic [2:0] {
        ST_ISSUE_P = 3'h0,
        ST_TAKE_P  = 3'h1,
        ST_ISSUE_S = 3'h2,
        ST_TAKE_S  = 3'h3,
        ST_EVAL    = 3'h4
    } cdrf_state_type;
endpackage : cdrf_pkg

// *** inc/cdrf_prof_if.sv ***
// Purpose: port of the profile memory between controller and storage
// Assumes: one access per cycle, read data one cycle late
// Notes:   no clock inside, both ends run on pclk
`timescale 1ns/10ps
interface cdrf_prof_if #(
    parameter int AW = 4,
    parameter int DW = 32
);
    logic [AW-1:0] addr;
    logic          we;
    logic [DW-1:0] wdata;
    logic [DW-1:0] rdata;
    modport ctl (output addr, output we, output wdata, input rdata);
    modport mem (input addr, input we, input wdata, output rdata);
endinterface : cdrf_prof_if

// *** rtl/cdrf_prof_mem.sv ***
// Purpose: translation profile storage, both dplls
// Assumes: single port, write and read on the same address
// Notes:   read data registered, old contents returned on a write cycle
`timescale 1ns/10ps
module cdrf_prof_mem #(
    parameter int DEPTH = 12,
    parameter int DW    = 32
) (
    input  wire logic pclk,
    input  wire logic presetn,
    cdrf_prof_if.mem  port
);
    typedef struct packed {
        logic [DEPTH-1:0][DW-1:0] mem;
        logic [DW-1:0]            rdata;
    } cdrf_mem_type;

    cdrf_mem_type r_q;
    cdrf_mem_type r_d;

    if (DEPTH < 1 || DEPTH > (1 << $bits(port.addr))) begin : g_chk
        $error("cdrf_prof_mem: depth does not fit the address");
    end

    ////////////////////////////////////////////////////////////////////////
    // next state: registered read of the old contents, then write
    always_comb begin
        r_d = r_q;
        if (int'(port.addr) < DEPTH) begin
            r_d.rdata = r_q.mem[port.addr];
            if (port.we) begin
                r_d.mem[port.addr] = port.wdata;
            end
        end else begin
            r_d.rdata = '0;
        end
    end

    // profiles clear to zero: no peer reference, buildout, no tagging
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r_q <= '0;
        end else begin
            r_q <= r_d;
        end
    end

    assign port.rdata = r_q.rdata;
endmodule : cdrf_prof_mem

// *** verification/cdrf_ref_partner.sv ***
// Purpose: far side model, reference status and apll of both channels
// Assumes: commands from the bench on pclk
// Notes:   slow mode reports loss of tracking four cycles late instead of one
`timescale 1ns/10ps
module cdrf_ref_partner (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic [1:0] ref_ok,
    input  wire logic [1:0] cal_cmd,
    input  wire logic [1:0] lock_cmd,
    input  wire logic [1:0] sync_cmd,
    input  wire logic       slow,
    output logic [1:0]      dpll_tracking,
    output logic [1:0]      apll_calibrated,
    output logic [1:0]      apll_locked,
    output logic [1:0]      dist_synced
);
    logic [3:0][1:0] trk_q;
    ////////////////////////////////////////////////////////////////
    // lock only reported once calibrated, as a real apll would
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trk_q <= '0;
            apll_calibrated <= '0;
            apll_locked <= '0;
            dist_synced <= '0;
        end else begin
            trk_q <= {trk_q[2:0], ref_ok};
            apll_calibrated <= cal_cmd;
            apll_locked <= lock_cmd & apll_calibrated;
            dist_synced <= sync_cmd;
        end
    end
    // each channel loses its reference on its own
    assign dpll_tracking = slow ? trk_q[3] : trk_q[0];
endmodule : cdrf_ref_partner

// *** verification/testbench.sv ***
// Purpose: self-checking bench for the cascaded dpll reference fallback
// Assumes: apb master on pclk, partner drives channel status
// Notes:   expectations come from arrays kept in the bench
`timescale 1ns/10ps
module testbench;
    logic             pclk, presetn, psel, penable, pwrite, pready, pslverr, slow;
    logic [15:0]      paddr;
    logic [31:0]      pwdata, prdata;
    logic [1:0]       apll_calibrated, apll_locked, dpll_tracking, dist_synced;
    logic [1:0]       peer_fb_ref_valid, peer_fb_tag_avail, ref_ok, cal_cmd, lock_cmd, sync_cmd;
    logic [1:0][15:0] cascade_fb_div_int;
    logic [31:0]      prof_m [12];
    logic [2:0]       sel_m [2];
    logic [1:0]       exp_v, exp_t, exp_c;
    int               fails, checks_done, seed;

    cdrf_fallback dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .apll_calibrated(apll_calibrated), .apll_locked(apll_locked), .dpll_tracking(dpll_tracking),
        .dist_synced(dist_synced), .peer_fb_ref_valid(peer_fb_ref_valid),
        .peer_fb_tag_avail(peer_fb_tag_avail), .cascade_fb_div_int(cascade_fb_div_int));
    cdrf_ref_partner far (.pclk(pclk), .presetn(presetn), .ref_ok(ref_ok), .cal_cmd(cal_cmd),
        .lock_cmd(lock_cmd), .sync_cmd(sync_cmd), .slow(slow), .dpll_tracking(dpll_tracking),
        .apll_calibrated(apll_calibrated), .apll_locked(apll_locked), .dist_synced(dist_synced));

    ////////////////////////////////////////////////////////////////
    // clock and watchdog; the limit is far above the planned run
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    initial begin
        repeat (60000) @(posedge pclk);
        fails++;
        $display("wrong value watchdog expected finish seen hang");
        close_out();
    end

    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : close_out

    task automatic cmp_reg(input string nm, input logic [31:0] ex, input logic [31:0] got);
        checks_done++;
        if (got !== ex) begin
            fails++;
            $display("wrong value %s expected %h seen %h", nm, ex, got);
        end
    endtask : cmp_reg

    task automatic cmp_out(input string nm, input logic [15:0] ex, input logic [15:0] got);
        checks_done++;
        if (got !== ex) begin
            fails++;
            $display("wrong value %s expected %h seen %h", nm, ex, got);
        end
    endtask : cmp_out

    ////////////////////////////////////////////////////////////////
    // apb transfer; request held until pready is sampled high
    task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic er);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        er = pslverr;
        if (n >= 50) cmp_reg("pready", 32'h1, 32'h0);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // model of both channels, compared with the outputs and status
    task automatic check_outputs();
        logic [31:0] w;
        logic        ex;
        logic [31:0] rd;
        logic        er;
        for (int p = 0; p < 2; p++) begin
            w = prof_m[p*6 + sel_m[p]];
            ex = 1'b0;
            for (int k = 0; k < 6; k++) ex |= prof_m[(1-p)*6 + k][0];
            exp_c[p] = ex; // peer profile found on the secondary
            exp_v[p] = ex & cal_cmd[p] & lock_cmd[p] & ~ref_ok[p] & (~w[1] | sync_cmd[1-p]);
            exp_t[p] = exp_v[p] & (w[4:2] inside {3'h2, 3'h3, 3'h4});
            cmp_out("valid", {15'h0, exp_v[p]}, {15'h0, peer_fb_ref_valid[p]});
            cmp_out("tag", {15'h0, exp_t[p]}, {15'h0, peer_fb_tag_avail[p]});
            cmp_out("div", w[23:8], cascade_fb_div_int[p]);
        end
        apb(1'b0, cdrf_pkg::ADDR_STATUS, 32'h0, rd, er);
        cmp_reg("status", {26'h0, exp_t, exp_c, exp_v}, rd);
    endtask : check_outputs

    ////////////////////////////////////////////////////////////////
    initial begin
        logic [31:0] rd, w;
        logic        er;
        logic [15:0] a;
        seed = 32'h2d35e9e4;
        {psel, penable, pwrite, slow} = 4'h0;
        paddr = 16'h0;
        pwdata = 32'h0;
        {ref_ok, cal_cmd, lock_cmd, sync_cmd} = 8'h00;
        for (int i = 0; i < 12; i++) prof_m[i] = 32'h0;
        presetn = 1'b0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        // reset values, then unmapped access is refused
        apb(1'b0, cdrf_pkg::ADDR_SEL0, 32'h0, rd, er);
        cmp_reg("sel0", 32'h0, rd);
        apb(1'b0, cdrf_pkg::ADDR_SEL1, 32'h0, rd, er);
        cmp_reg("sel1", 32'h0, rd);
        apb(1'b0, 16'h0014, 32'h0, rd, er);
        cmp_reg("prof", 32'h0, rd);
        apb(1'b1, 16'h0038, 32'h5, rd, er);
        cmp_reg("err", 32'h1, {31'h0, er});
        apb(1'b0, 16'h0038, 32'h0, rd, er);
        cmp_reg("unmapped", 32'h1, {rd[30:0], er});
        // every selector code, six and seven left without effect
        for (int p = 0; p < 2; p++) begin
            a = p ? cdrf_pkg::ADDR_SEL1 : cdrf_pkg::ADDR_SEL0;
            sel_m[p] = 3'h0;
            for (int v = 0; v < 8; v++) begin
                apb(1'b1, a, 32'(v), rd, er);
                if (v <= 5) sel_m[p] = 3'(v);
                apb(1'b0, a, 32'h0, rd, er);
                cmp_reg("sel", {29'h0, sel_m[p]}, rd);
            end
        end
        // random profiles, selectors and channel states, both roles
        // reference synchronisation is never requested while cascading
        for (int it = 0; it < 40; it++) begin
            for (int i = 0; i < 12; i++) begin
                w = $random(seed);
                w[0] = (($random(seed) & 7) == 0);
                w[4:2] = 3'((it + i) % 5);
                w[5] = 1'b0;
                prof_m[i] = w;
                apb(1'b1, 16'(i*4), w, rd, er);
            end
            apb(1'b0, 16'((it % 12) * 4), 32'h0, rd, er);
            cmp_reg("prof", prof_m[it % 12], rd);
            for (int p = 0; p < 2; p++) begin
                sel_m[p] = 3'(($random(seed) & 32'hff) % 6);
                a = p ? cdrf_pkg::ADDR_SEL1 : cdrf_pkg::ADDR_SEL0;
                apb(1'b1, a, {29'h0, sel_m[p]}, rd, er);
            end
            repeat (48) @(posedge pclk);
            for (int k = 0; k < 4; k++) begin
                w = $random(seed);
                ref_ok <= w[1:0];
                cal_cmd <= w[3:2] | w[5:4];
                lock_cmd <= w[7:6] | w[9:8];
                sync_cmd <= w[11:10];
                slow <= w[12];
                repeat (10) @(posedge pclk);
                check_outputs();
            end
        end
        close_out();
    end
endmodule : testbench
